// ---- logic/alsc_pkg.sv ----
package alsc_pkg;
   // ==========================================================
   // Timing
   localparam int unsigned CLK_PERIOD_NS  = 25;
   localparam int unsigned TICK_PERIOD_NS = 1_000_000;
   localparam int unsigned TICK_CYCLES    = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // ==========================================================
   // Register byte offsets
   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_HOLD   = 12'h004;
   localparam logic [11:0] OFS_SPEED  = 12'h008;
   localparam logic [11:0] OFS_FLIM   = 12'h00C;
   localparam logic [11:0] OFS_STATUS = 12'h010;
   localparam logic [11:0] OFS_APPLY  = 12'h014;
   // ==========================================================
   // Field positions and writable masks
   localparam int unsigned CTRL_PRI_LSB  = 0;
   localparam int unsigned CTRL_G2_BIT   = 4;
   localparam int unsigned CTRL_LV_LSB   = 8;
   localparam int unsigned CTRL_MODE_LSB = 12;
   localparam int unsigned FLIM_REL_LSB  = 16;
   localparam int unsigned STAT_MS_LSB   = 16;
   localparam logic [31:0] CTRL_MASK  = 32'h0000_3313;
   localparam logic [31:0] HOLD_MASK  = 32'h0000_07FF;
   localparam logic [31:0] SPEED_MASK = 32'h0000_007F;
   localparam logic [31:0] FLIM_MASK  = 32'h03FF_007F;
   // ==========================================================
   // Values after reset and legal ranges
   localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
   localparam logic [31:0] HOLD_RST  = 32'h0000_0014;
   localparam logic [31:0] SPEED_RST = 32'h0000_0032;
   localparam logic [31:0] FLIM_RST  = 32'h0064_0032;
   localparam logic [10:0] HOLD_MIN  = 11'h014;
   localparam logic [10:0] HOLD_MAX  = 11'h3E8;
   localparam logic [6:0]  SPEED_MIN = 7'h01;
   localparam logic [6:0]  SPEED_MAX = 7'h64;
   localparam logic [15:0] SPEED_UNIT = 16'h0064;
   localparam logic [6:0]  PCT_FULL  = 7'h64;
   localparam logic [9:0]  REL_MAX   = 10'h3E8;
   // ==========================================================
   // Encodings
   localparam logic [1:0] PRI_DB_HOLD  = 2'h0;
   localparam logic [1:0] PRI_DB_COAST = 2'h1;
   localparam logic [1:0] PRI_COAST    = 2'h2;
   localparam logic [1:0] LV_NONE      = 2'h0;
   localparam logic [1:0] LV_HOST      = 2'h1;
   localparam logic [1:0] LV_SELF      = 2'h2;
   localparam logic [1:0] MODE_FORCE   = 2'h2;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   typedef enum logic [2:0] {
      ST_RUN, ST_ZERO_STOP, ST_DB_STOP, ST_COAST_STOP, ST_HOLD_DB, ST_HOLD_COAST
   } alsc_state_t;
endpackage

// ---- logic/alsc_top.sv ----
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module alsc_top #(
   parameter int unsigned TICK_CYCLES = alsc_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        SRST,
   // AXI4-Lite slave
   input  wire logic [11:0] S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [11:0] S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY,
   // Pins from host and power stage
   input  wire logic        SERVO_ON,
   input  wire logic        ALARM_GROUP_ONE,
   input  wire logic        ALARM_GROUP_TWO,
   input  wire logic        MAIN_PWR_OK,
   input  wire logic        CTRL_PWR_OK,
   input  wire logic        UNDERVOLT_ALARM,
   input  wire logic        MAIN_LOW_VOLT,
   input  wire logic        MOTOR_STOPPED,
   // Speed feedback, same clock
   input  wire logic [15:0] SPEED_MM_S,
   // Power stage and status outputs
   output logic             MOTOR_PWR_EN,
   output logic             DYNAMIC_BRAKING_EN,
   output logic             ZERO_SPEED_CMD,
   output logic             POWER_CUT_FLAG,
   output logic             OVERSPEED_ALARM,
   output logic             LOW_VOLT_WARN,
   output logic [6:0]       FORCE_LIMIT_PCT
);
   // ==========================================================
   // Parameter check
   if (TICK_CYCLES < 2 || TICK_CYCLES > 32'h00FF_FFFF)
   begin : g_bad_tick
      $error("TICK_CYCLES out of range");
   end
   localparam int unsigned TW = $clog2(TICK_CYCLES);

   function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] strb, input logic [31:0] mask);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++)
         if (strb[i])
            r[8*i +: 8] = nw[8*i +: 8];
      return r & mask;
   endfunction

   // ==========================================================
   // Pin synchronisers: change accepted once stages two and three agree
   localparam int NP = 8;
   logic [NP-1:0] pin_raw, s1_q, s2_q, s3_q, pin_q;
   assign pin_raw = {MOTOR_STOPPED, MAIN_LOW_VOLT, UNDERVOLT_ALARM, CTRL_PWR_OK,
                     MAIN_PWR_OK, ALARM_GROUP_TWO, ALARM_GROUP_ONE, SERVO_ON};
   for (genvar g = 0; g < NP; g++)
   begin : g_sync
      always_ff @(posedge CLK)
      begin
         s1_q[g] <= pin_raw[g];
         s2_q[g] <= s1_q[g];
         s3_q[g] <= s2_q[g];
         if (SRST)
            pin_q[g] <= (g == 3 || g == 4);
         else if (s2_q[g] == s3_q[g])
            pin_q[g] <= s3_q[g];
      end
   end
   logic servo_on, alm_g1, alm_g2, main_ok, ctrl_ok, uv_alm, low_v, stopped;
   assign {stopped, low_v, uv_alm, ctrl_ok, main_ok, alm_g2, alm_g1, servo_on} = pin_q;

   // ==========================================================
   // AXI4-Lite slave
   logic [31:0] ctrl_q, hold_q, speed_q, flim_q, wdata_q, rdata_d;
   logic [11:0] awaddr_q;
   logic [3:0]  wstrb_q;
   logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q, apply_q;
   logic [1:0]  bresp_q, rresp_q, rresp_d;
   logic [31:0] rdata_q, status_w;
   logic        do_write, wr_ok;
   assign do_write = !awready_q && !wready_q && !bvalid_q;
   assign wr_ok    = awaddr_q inside {alsc_pkg::OFS_CTRL, alsc_pkg::OFS_HOLD,
                     alsc_pkg::OFS_SPEED, alsc_pkg::OFS_FLIM, alsc_pkg::OFS_APPLY};

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         awready_q <= 1'b1;
         wready_q  <= 1'b1;
         bvalid_q  <= 1'b0;
         bresp_q   <= alsc_pkg::RESP_OKAY;
         awaddr_q  <= 12'h000;
         wdata_q   <= 32'h0000_0000;
         wstrb_q   <= 4'h0;
      end
      else
      begin
         if (awready_q && S_AXI_AWVALID)
         begin
            awaddr_q  <= {S_AXI_AWADDR[11:2], 2'b00};
            awready_q <= 1'b0;
         end
         if (wready_q && S_AXI_WVALID)
         begin
            wdata_q  <= S_AXI_WDATA;
            wstrb_q  <= S_AXI_WSTRB;
            wready_q <= 1'b0;
         end
         if (do_write)
         begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_ok ? alsc_pkg::RESP_OKAY : alsc_pkg::RESP_SLVERR;
         end
         if (bvalid_q && S_AXI_BREADY)
         begin
            bvalid_q  <= 1'b0;
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
         end
      end
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         ctrl_q  <= alsc_pkg::CTRL_RST;
         hold_q  <= alsc_pkg::HOLD_RST;
         speed_q <= alsc_pkg::SPEED_RST;
         flim_q  <= alsc_pkg::FLIM_RST;
         apply_q <= 1'b0;
      end
      else
      begin
         apply_q <= do_write && awaddr_q == alsc_pkg::OFS_APPLY && wstrb_q[0] && wdata_q[0];
         if (do_write)
            case (awaddr_q)
               alsc_pkg::OFS_CTRL:
                  ctrl_q  <= wmerge(ctrl_q, wdata_q, wstrb_q, alsc_pkg::CTRL_MASK);
               alsc_pkg::OFS_HOLD:
                  hold_q  <= wmerge(hold_q, wdata_q, wstrb_q, alsc_pkg::HOLD_MASK);
               alsc_pkg::OFS_SPEED:
                  speed_q <= wmerge(speed_q, wdata_q, wstrb_q, alsc_pkg::SPEED_MASK);
               alsc_pkg::OFS_FLIM:
                  flim_q  <= wmerge(flim_q, wdata_q, wstrb_q, alsc_pkg::FLIM_MASK);
               default:
                  ;
            endcase
      end
   end

   always_comb
   begin
      rdata_d = 32'h0000_0000;
      rresp_d = alsc_pkg::RESP_OKAY;
      case ({S_AXI_ARADDR[11:2], 2'b00})
         alsc_pkg::OFS_CTRL:   rdata_d = ctrl_q;
         alsc_pkg::OFS_HOLD:   rdata_d = hold_q;
         alsc_pkg::OFS_SPEED:  rdata_d = speed_q;
         alsc_pkg::OFS_FLIM:   rdata_d = flim_q;
         alsc_pkg::OFS_STATUS: rdata_d = status_w;
         alsc_pkg::OFS_APPLY:  rdata_d = 32'h0000_0000;
         default:              rresp_d = alsc_pkg::RESP_SLVERR;
      endcase
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0000_0000;
         rresp_q   <= alsc_pkg::RESP_OKAY;
      end
      else if (arready_q && S_AXI_ARVALID)
      begin
         arready_q <= 1'b0;
         rvalid_q  <= 1'b1;
         rdata_q   <= rdata_d;
         rresp_q   <= rresp_d;
      end
      else if (rvalid_q && S_AXI_RREADY)
      begin
         arready_q <= 1'b1;
         rvalid_q  <= 1'b0;
      end
   end

   // ==========================================================
   // Settings that only take effect at restart (reset or apply)
   logic [1:0]  pri_q, lvsel_q, mode_q;
   logic        g2sel_q;
   logic [6:0]  maxspd_q, lvl_w;
   logic [10:0] hold_w;
   logic [9:0]  rel_w;
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         pri_q    <= alsc_pkg::CTRL_RST[alsc_pkg::CTRL_PRI_LSB +: 2];
         g2sel_q  <= alsc_pkg::CTRL_RST[alsc_pkg::CTRL_G2_BIT];
         lvsel_q  <= alsc_pkg::CTRL_RST[alsc_pkg::CTRL_LV_LSB +: 2];
         maxspd_q <= alsc_pkg::SPEED_RST[6:0];
      end
      else if (apply_q)
      begin
         pri_q    <= (ctrl_q[1:0] > alsc_pkg::PRI_COAST) ? alsc_pkg::PRI_COAST : ctrl_q[1:0];
         g2sel_q  <= ctrl_q[alsc_pkg::CTRL_G2_BIT];
         lvsel_q  <= (ctrl_q[9:8] > alsc_pkg::LV_SELF) ? alsc_pkg::LV_SELF : ctrl_q[9:8];
         maxspd_q <= (speed_q[6:0] < alsc_pkg::SPEED_MIN) ? alsc_pkg::SPEED_MIN :
                     (speed_q[6:0] > alsc_pkg::SPEED_MAX) ? alsc_pkg::SPEED_MAX : speed_q[6:0];
      end
   end
   // Control mode, hold time, limit level and release time act at once
   assign mode_q = ctrl_q[alsc_pkg::CTRL_MODE_LSB +: 2];
   assign hold_w = (hold_q[10:0] < alsc_pkg::HOLD_MIN) ? alsc_pkg::HOLD_MIN :
                   (hold_q[10:0] > alsc_pkg::HOLD_MAX) ? alsc_pkg::HOLD_MAX : hold_q[10:0];
   assign lvl_w  = (flim_q[6:0] > alsc_pkg::PCT_FULL) ? alsc_pkg::PCT_FULL : flim_q[6:0];
   assign rel_w  = (flim_q[25:16] > alsc_pkg::REL_MAX) ? alsc_pkg::REL_MAX : flim_q[25:16];

   // ==========================================================
   // Millisecond tick and interruption timer
   logic [TW-1:0] tick_cnt_q;
   logic          tick_q, cut_q, pcf_q;
   logic [10:0]   off_ms_q;
   always_ff @(posedge CLK)
   begin
      if (SRST || tick_cnt_q == TW'(TICK_CYCLES - 1))
         tick_cnt_q <= '0;
      else
         tick_cnt_q <= tick_cnt_q + 1'b1;
      tick_q <= !SRST && tick_cnt_q == TW'(TICK_CYCLES - 1);
   end

   // Motor power stays removed until supply is back and host drops servo-on
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         off_ms_q <= 11'h000;
         cut_q    <= 1'b0;
         pcf_q    <= 1'b0;
      end
      else
      begin
         pcf_q <= !main_ok;
         if (main_ok)
            off_ms_q <= 11'h000;
         else if (tick_q && off_ms_q != alsc_pkg::HOLD_MAX)
            off_ms_q <= off_ms_q + 11'h001;
         if (!main_ok && tick_q && off_ms_q + 11'h001 >= hold_w)
            cut_q <= 1'b1;
         else if (main_ok && !servo_on)
            cut_q <= 1'b0;
      end
   end

   // ==========================================================
   // Overspeed
   logic [15:0] spd_lim;
   logic        ovs_q;
   assign spd_lim = 16'(maxspd_q) * alsc_pkg::SPEED_UNIT;
   always_ff @(posedge CLK)
   begin
      if (SRST)
         ovs_q <= 1'b0;
      else if (SPEED_MM_S > spd_lim)
         ovs_q <= 1'b1;
      else if (!servo_on)
         ovs_q <= 1'b0;
   end

   // ==========================================================
   // Stop sequencing
   alsc_pkg::alsc_state_t st_q, st_d;
   logic stop_req, zs_sel, go_stop;
   // Undervoltage and control loss bypass the hold timer entirely
   assign stop_req = !servo_on || alm_g1 || ovs_q || cut_q
                     || uv_alm || !ctrl_ok;
   assign zs_sel   = alm_g2 && !stop_req && !g2sel_q
                     && mode_q != alsc_pkg::MODE_FORCE;
   assign go_stop  = stop_req || alm_g2;

   always_comb
   begin
      st_d = st_q;
      case (st_q)
         alsc_pkg::ST_RUN:
            if (zs_sel)
               st_d = alsc_pkg::ST_ZERO_STOP;
            else if (go_stop)
               st_d = (pri_q == alsc_pkg::PRI_COAST) ? alsc_pkg::ST_COAST_STOP
                                                     : alsc_pkg::ST_DB_STOP;
         alsc_pkg::ST_ZERO_STOP:
            if (stopped)
               st_d = (pri_q == alsc_pkg::PRI_DB_HOLD) ? alsc_pkg::ST_HOLD_DB
                                                       : alsc_pkg::ST_HOLD_COAST;
         alsc_pkg::ST_DB_STOP:
            if (stopped)
               st_d = (pri_q == alsc_pkg::PRI_DB_HOLD) ? alsc_pkg::ST_HOLD_DB
                                                       : alsc_pkg::ST_HOLD_COAST;
         alsc_pkg::ST_COAST_STOP:
            if (stopped)
               st_d = alsc_pkg::ST_HOLD_COAST;
         alsc_pkg::ST_HOLD_DB, alsc_pkg::ST_HOLD_COAST:
            if (!go_stop)
               st_d = alsc_pkg::ST_RUN;
         default:
            st_d = alsc_pkg::ST_HOLD_DB;
      endcase
   end

   logic pwr_q, db_q, zs_q;
   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         st_q  <= alsc_pkg::ST_HOLD_DB;
         pwr_q <= 1'b0;
         db_q  <= 1'b1;
         zs_q  <= 1'b0;
      end
      else
      begin
         st_q  <= st_d;
         pwr_q <= st_d inside {alsc_pkg::ST_RUN, alsc_pkg::ST_ZERO_STOP};
         db_q  <= st_d inside {alsc_pkg::ST_DB_STOP, alsc_pkg::ST_HOLD_DB};
         zs_q  <= st_d == alsc_pkg::ST_ZERO_STOP;
      end
   end

   // ==========================================================
   // Low main-voltage force limit
   logic        warn_q, lim_on_q, rel_q;
   logic [9:0]  rel_ms_q;
   logic [6:0]  flp_q, flp_d;
   logic [16:0] ramp_num;
   assign ramp_num = 17'(alsc_pkg::PCT_FULL - lvl_w) * 17'(rel_ms_q);
   always_comb
   begin
      flp_d = alsc_pkg::PCT_FULL;
      if (lim_on_q)
         flp_d = lvl_w;
      else if (rel_q && rel_w != 10'h000)
         flp_d = lvl_w + 7'(ramp_num / 17'(rel_w));
   end

   always_ff @(posedge CLK)
   begin
      if (SRST)
      begin
         warn_q   <= 1'b0;
         lim_on_q <= 1'b0;
         rel_q    <= 1'b0;
         rel_ms_q <= 10'h000;
         flp_q    <= alsc_pkg::PCT_FULL;
      end
      else
      begin
         warn_q   <= lvsel_q != alsc_pkg::LV_NONE && low_v;
         lim_on_q <= lvsel_q == alsc_pkg::LV_SELF && low_v;
         flp_q    <= flp_d;
         if (lim_on_q && !(lvsel_q == alsc_pkg::LV_SELF && low_v))
         begin
            rel_q    <= 1'b1;
            rel_ms_q <= 10'h000;
         end
         else if (lim_on_q || rel_ms_q >= rel_w)
            rel_q <= 1'b0;
         else if (rel_q && tick_q)
            rel_ms_q <= rel_ms_q + 10'h001;
      end
   end

   assign status_w = {5'h00, off_ms_q, 4'h0, 3'(st_q), rel_q, lim_on_q, warn_q,
                      ovs_q, cut_q, pcf_q, zs_q, db_q, pwr_q};

   // ==========================================================
   // Outputs
   assign S_AXI_AWREADY      = awready_q;
   assign S_AXI_WREADY       = wready_q;
   assign S_AXI_BVALID       = bvalid_q;
   assign S_AXI_BRESP        = bresp_q;
   assign S_AXI_ARREADY      = arready_q;
   assign S_AXI_RVALID       = rvalid_q;
   assign S_AXI_RDATA        = rdata_q;
   assign S_AXI_RRESP        = rresp_q;
   assign MOTOR_PWR_EN       = pwr_q;
   assign DYNAMIC_BRAKING_EN = db_q;
   assign ZERO_SPEED_CMD     = zs_q;
   assign POWER_CUT_FLAG     = pcf_q;
   assign OVERSPEED_ALARM    = ovs_q;
   assign LOW_VOLT_WARN      = warn_q;
   assign FORCE_LIMIT_PCT    = flp_q;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge CLK); endclocking
   default disable iff (SRST);
   property p_g1_stop;
      (st_q == alsc_pkg::ST_RUN && alm_g1) |=> !MOTOR_PWR_EN ##0 st_q != alsc_pkg::ST_ZERO_STOP;
   endproperty
   a_g1_stop: assert property (p_g1_stop) else $error("group one alarm did not stop");
   property p_coast;
      (st_q == alsc_pkg::ST_RUN && stop_req && pri_q == alsc_pkg::PRI_COAST)
         |=> (st_q == alsc_pkg::ST_COAST_STOP && !DYNAMIC_BRAKING_EN);
   endproperty
   a_coast: assert property (p_coast) else $error("coast stop not taken");
   property p_zero;
      (st_q == alsc_pkg::ST_RUN && alm_g2 && !stop_req && !g2sel_q
         && mode_q != alsc_pkg::MODE_FORCE) |=> ZERO_SPEED_CMD && MOTOR_PWR_EN;
   endproperty
   a_zero: assert property (p_zero) else $error("zero speed stop missing");
   property p_zero_hold;
      (st_q == alsc_pkg::ST_ZERO_STOP && stopped && pri_q == alsc_pkg::PRI_DB_HOLD)
         |=> st_q == alsc_pkg::ST_HOLD_DB ##1 DYNAMIC_BRAKING_EN;
   endproperty
   a_zero_hold: assert property (p_zero_hold) else $error("no brake hold");
   property p_g2_primary;
      (st_q == alsc_pkg::ST_RUN && alm_g2 && (g2sel_q || mode_q == alsc_pkg::MODE_FORCE))
         |=> !ZERO_SPEED_CMD && !MOTOR_PWR_EN;
   endproperty
   a_g2_primary: assert property (p_g2_primary) else $error("group two stop wrong");
   property p_flag;
      !main_ok |=> POWER_CUT_FLAG;
   endproperty
   a_flag: assert property (p_flag) else $error("interruption flag missing");
   property p_cut_tick;
      $rose(cut_q) |-> $past(tick_q) && $past(off_ms_q) + 11'h001 >= $past(hold_w);
   endproperty
   a_cut_tick: assert property (p_cut_tick) else $error("power removed early");
   property p_uv;
      (uv_alm || !ctrl_ok) && st_q == alsc_pkg::ST_RUN |=> !MOTOR_PWR_EN;
   endproperty
   a_uv: assert property (p_uv) else $error("supply fault ignored");
   property p_ovs;
      SPEED_MM_S > spd_lim |=> OVERSPEED_ALARM ##1 !MOTOR_PWR_EN;
   endproperty
   a_ovs: assert property (p_ovs) else $error("overspeed not flagged");
   property p_self_lim;
      (lvsel_q == alsc_pkg::LV_SELF && low_v && $stable(lvl_w))[*2]
         |=> FORCE_LIMIT_PCT == $past(lvl_w);
   endproperty
   a_self_lim: assert property (p_self_lim) else $error("force not limited");
   c_g1: cover property (st_q == alsc_pkg::ST_RUN ##1 st_q == alsc_pkg::ST_DB_STOP);
   c_zero: cover property (st_q == alsc_pkg::ST_ZERO_STOP ##1 st_q == alsc_pkg::ST_HOLD_COAST);
   c_cut: cover property ($rose(cut_q));
   c_rel: cover property ($fell(rel_q) && FORCE_LIMIT_PCT != alsc_pkg::PCT_FULL);
endmodule

// ---- sim/alsc_stage.sv ----
`timescale 1ns/1ps
// ==========================================
// Power stage model: motor glides to rest a while after torque goes
module alsc_stage (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        srst,
   // From drive
   input  wire logic        pwr_en,
   input  wire logic        zero_cmd,
   // To drive
   output logic             stopped,
   output logic [15:0]      speed
);
   logic [3:0] dwell_q;
   always_ff @(posedge clk)
   begin
      if (srst || (pwr_en && !zero_cmd))
         dwell_q <= 4'h0;
      else if (dwell_q != 4'hF)
         dwell_q <= dwell_q + 4'h1;
   end
   // Slow rest keeps the stop states visible for a few cycles
   assign stopped = dwell_q > 4'hA;
   assign speed   = stopped ? 16'h0000 : 16'h03E8;
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
// ==========================================
// Bench
module tb_top;
   logic CLK = 0, SRST = 1, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 0;
   logic S_AXI_ARVALID = 0, S_AXI_RREADY = 0, SERVO_ON = 0, ALARM_GROUP_ONE = 0;
   logic ALARM_GROUP_TWO = 0, MAIN_PWR_OK = 1, CTRL_PWR_OK = 1, UNDERVOLT_ALARM = 0;
   logic MAIN_LOW_VOLT = 0, S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY;
   logic S_AXI_RVALID, MOTOR_STOPPED, MOTOR_PWR_EN, DYNAMIC_BRAKING_EN, ZERO_SPEED_CMD;
   logic POWER_CUT_FLAG, OVERSPEED_ALARM, LOW_VOLT_WARN;
   logic [11:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0;
   logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
   logic [3:0]  S_AXI_WSTRB = 4'hF;
   logic [1:0]  S_AXI_BRESP, S_AXI_RRESP;
   logic [15:0] SPEED_MM_S;
   logic [6:0]  FORCE_LIMIT_PCT;
   int          mismatches = 0, total_checks = 0;
   always #12.5 CLK = ~CLK;
   alsc_top #(.TICK_CYCLES(8)) u_alsc_top (.*);
   alsc_stage u_alsc_stage (.clk(CLK), .srst(SRST), .pwr_en(MOTOR_PWR_EN),
      .zero_cmd(ZERO_SPEED_CMD), .stopped(MOTOR_STOPPED), .speed(SPEED_MM_S));
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // A bus answer that never comes counts as a mismatch
   task lost;
      mismatches++;
      $display("CHECK FAILED t=%0t no bus answer", $time);
      end_sim;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task step(input int n);
      repeat (n) @(posedge CLK);
   endtask
   // Bounded waits: a lost answer counts and ends the run
   task wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge CLK);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_AWVALID <= 1;
      S_AXI_WVALID <= 1;
      S_AXI_BREADY <= 1;
      do
      begin
         @(posedge CLK);
         n++;
         if (S_AXI_AWREADY) S_AXI_AWVALID <= 0;
         if (S_AXI_WREADY) S_AXI_WVALID <= 0;
      end while (!S_AXI_BVALID && n < 60);
      S_AXI_BREADY <= 0;
      chk(32'(S_AXI_BRESP), 32'(er));
      if (!S_AXI_BVALID) lost;
   endtask
   task rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
      int n;
      n = 0;
      @(posedge CLK);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1;
      S_AXI_RREADY <= 1;
      do
      begin
         @(posedge CLK);
         n++;
         if (S_AXI_ARREADY) S_AXI_ARVALID <= 0;
      end while (!S_AXI_RVALID && n < 60);
      S_AXI_RREADY <= 0;
      chk(S_AXI_RDATA, ed);
      chk(32'(S_AXI_RRESP), 32'(er));
      if (!S_AXI_RVALID) lost;
   endtask
   task recover;
      {ALARM_GROUP_ONE, ALARM_GROUP_TWO, UNDERVOLT_ALARM} <= 3'h0;
      {MAIN_PWR_OK, CTRL_PWR_OK, SERVO_ON} <= 3'h6;
      step(30);
      SERVO_ON <= 1;
      step(40);
      chk(MOTOR_PWR_EN, 1);
   endtask
   initial
   begin
      step(4);
      SRST <= 0;
      rd(alsc_pkg::OFS_CTRL, alsc_pkg::CTRL_RST, alsc_pkg::RESP_OKAY);
      rd(alsc_pkg::OFS_HOLD, alsc_pkg::HOLD_RST, alsc_pkg::RESP_OKAY);
      rd(12'hFF0, 32'h0, alsc_pkg::RESP_SLVERR);
      wr(alsc_pkg::OFS_STATUS, 32'h0, alsc_pkg::RESP_SLVERR);
      recover();
      MAIN_PWR_OK <= 0;
      step(80);
      chk(POWER_CUT_FLAG, 1);
      MAIN_PWR_OK <= 1;
      step(10);
      chk(MOTOR_PWR_EN, 1);
      MAIN_PWR_OK <= 0;
      step(175);
      chk(MOTOR_PWR_EN, 0);
      recover();
      {MAIN_PWR_OK, UNDERVOLT_ALARM} <= 2'h1;
      step(30);
      chk(MOTOR_PWR_EN, 0);
      recover();
      CTRL_PWR_OK <= 0;
      step(30);
      chk(MOTOR_PWR_EN, 0);
      recover();
      for (int p = 0; p < 3; p++)
         for (int m = 0; m < 4; m++)
         begin
            wr(alsc_pkg::OFS_CTRL, p | (m == 1 ? 32'h10 : 0) | (m == 3 ? 32'h2000 : 0),
               alsc_pkg::RESP_OKAY);
            wr(alsc_pkg::OFS_APPLY, 32'h1, alsc_pkg::RESP_OKAY);
            recover();
            {ALARM_GROUP_ONE, ALARM_GROUP_TWO} <= (m == 0) ? 2'h2 : 2'h1;
            step(9);
            chk(ZERO_SPEED_CMD, m == 2);
            chk(MOTOR_PWR_EN, m == 2);
            step(40);
            chk(DYNAMIC_BRAKING_EN, p == 0);
         end
      for (int v = 0; v < 3; v++)
      begin
         wr(alsc_pkg::OFS_CTRL, v << 8, alsc_pkg::RESP_OKAY);
         wr(alsc_pkg::OFS_APPLY, 32'h1, alsc_pkg::RESP_OKAY);
         MAIN_LOW_VOLT <= 1;
         step(10);
         chk(LOW_VOLT_WARN, v != 0);
         chk(FORCE_LIMIT_PCT, v == 2 ? 50 : 100);
         MAIN_LOW_VOLT <= 0;
         step(830);
         chk(FORCE_LIMIT_PCT, 100);
      end
      // Motor must be moving so that the lowered limit is exceeded
      recover();
      wr(alsc_pkg::OFS_SPEED, 32'h0, alsc_pkg::RESP_OKAY);
      rd(alsc_pkg::OFS_SPEED, 32'h0, alsc_pkg::RESP_OKAY);
      wr(alsc_pkg::OFS_APPLY, 32'h1, alsc_pkg::RESP_OKAY);
      step(20);
      chk(OVERSPEED_ALARM, 1);
      chk(MOTOR_PWR_EN, 0);
      end_sim();
   end
endmodule
